// File: include/uocr_pkg.sv
package uocr_pkg;

  // Register byte offsets
  localparam logic [11:0] CAPABILITY_WORD_OFS     = 12'h81C;
  localparam logic [11:0] ADDRESS_SPACE_SIZE_OFS  = 12'h820;
  localparam logic [11:0] BLOCK_NAME_PART_ONE_OFS = 12'h824;
  localparam logic [11:0] BLOCK_NAME_PART_TWO_OFS = 12'h828;
  localparam logic [11:0] ROLE_STATE_STATUS_OFS   = 12'h82C;

  // Capability word field positions
  localparam int HB_ISO_LSB       = 17;
  localparam int HB_ISO_EPS       = 7;
  localparam int UTMI_FLAG_BIT    = 16;
  localparam int BYTE_LANE_BIT    = 15;
  localparam int MEM_SIZE_LSB     = 12;
  localparam int FIFO_DEPTH_LSB   = 8;
  localparam int DMA_LEN_BIT      = 7;
  localparam int DMA_CHAN_LSB     = 4;
  localparam int ENDPOINT_CNT_LSB = 0;

  // Capability values of this build
  localparam logic [6:0] HB_ISO_SUPPORTED_N      = 7'h7F;
  localparam logic       UTMI_PATH_WIDTH_FLAG    = 1'h1;
  localparam logic       NATIVE_BYTE_LANE_FLAG   = 1'h0;
  localparam logic [2:0] PACKET_MEMORY_SIZE_CODE = 3'h6;
  localparam logic [3:0] DMA_FIFO_DEPTH_CODE     = 4'h0;
  localparam logic       DMA_LENGTH_WIDTH_FLAG   = 1'h1;
  localparam logic [2:0] DMA_CHANNEL_COUNT       = 3'h7;
  localparam logic [3:0] ENDPOINT_COUNT          = 4'h8;

  // Size and name words; values are arbitrary
  localparam logic [31:0] ADDRESS_SPACE_SIZE  = 32'h00001000;
  localparam logic [31:0] BLOCK_NAME_PART_ONE = 32'h4F54475F;
  localparam logic [31:0] BLOCK_NAME_PART_TWO = 32'h43545231;

  // Reset value of the state status word
  localparam logic [31:0] ROLE_STATE_RESET = 32'h00000009;

  // Timing
  localparam int CLK_MHZ          = 100;
  localparam int DISCHARGE_US     = 100;
  localparam int HNP_WAIT_US      = 3000;
  localparam int DISCHARGE_CYCLES = DISCHARGE_US * CLK_MHZ;
  localparam int HNP_WAIT_CYCLES  = HNP_WAIT_US * CLK_MHZ;
  localparam int TIMER_W          = 20;
  localparam int SETTLE_CYCLES    = 3;

  // Pin inputs, in synchroniser bit order
  localparam int PIN_W            = 7;
  localparam int PIN_ID           = 0;
  localparam int PIN_VBUS_VALID   = 1;
  localparam int PIN_SESS_VALID   = 2;
  localparam int PIN_OVERCURRENT  = 3;
  localparam int PIN_FAR_CONNECT  = 4;
  localparam int PIN_LINE_SUSPEND = 5;
  localparam int PIN_LINE_RESUME  = 6;

  // Dual-role states in code order 0..15
  typedef enum logic [3:0] {
    A_IDLE, A_WAIT_VRISE, A_WAIT_BCON, A_HOST, A_SUSPEND, A_PERIPHERAL,
    A_WAIT_VFALL, A_VBUS_ERR, A_WAIT_DISCHARGE, B_IDLE, B_PERIPHERAL,
    B_WAIT_BEGIN_HNP, B_WAIT_DISCHARGE, B_WAIT_ACON, B_HOST, B_SRP_INIT
  } uocr_state_t;

endpackage

// File: logic/uocr_sync.sv
`timescale 1ns/1ps
module uocr_sync
  import uocr_pkg::*;
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // Pins in, synchronised out
  input  wire logic [PIN_W-1:0] pin_async,
  output logic      [PIN_W-1:0] pin_sync
);
  import uocr_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] first;
    logic [PIN_W-1:0] second;
  } uocr_sync_t;

  uocr_sync_t s;
  uocr_sync_t next_s;

  // First stage feeds only the second
  always_comb
  begin
    next_s = s;
    next_s.first = pin_async;
    next_s.second = s.first;
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  genvar b;
  generate
    for (b = 0; b < PIN_W; b++)
    begin : g_out
      assign pin_sync[b] = s.second[b];
    end
  endgenerate
endmodule // uocr_sync

// File: logic/uocr_timer.sv
`timescale 1ns/1ps
module uocr_timer
  import uocr_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset_n,
  // Control
  input  wire logic               start,
  input  wire logic [TIMER_W-1:0] load,
  // Expiry pulse
  output logic                    done
);
  import uocr_pkg::*;

  typedef struct packed {
    logic [TIMER_W-1:0] count;
    logic               running;
    logic               done;
  } uocr_timer_t;

  uocr_timer_t s;
  uocr_timer_t next_s;

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    // Restart also drops a stale expiry
    if (start)
    begin
      next_s.count = (load == '0) ? TIMER_W'(1) : load;
      next_s.running = 1'b1;
    end
    else if (s.running)
    begin
      if (s.count == TIMER_W'(1))
      begin
        next_s.running = 1'b0;
        next_s.done = 1'b1;
      end
      next_s.count = s.count - TIMER_W'(1);
    end
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s <= '0;
    else
      s <= next_s;
  end

  assign done = s.done;
endmodule // uocr_timer

// File: logic/uocr_top.sv
// What this block does
// - Each endpoint reports 1 if high-bandwidth isochronous is supported, else 0.
// - Transceiver path flag: 1 for 16-bit at 30MHz, 0 for 8-bit at 60MHz.
// - Byte-write flag: 1 native memory byte writes, 0 emulated byte lanes.
// - Memory size code 0..6 below 256..16384 bytes, 7 means 16384 or more.
// - DMA FIFO depth code 1..15 direct, 0 means 16 words.
// - DMA length flag: 1 for 24-bit buffer size, 0 for 16-bit.
// - DMA channel count 1..7 direct, code 0 reserved.
// - Endpoint count 1..15 direct, 0 means 16.
// - Read-only word gives the register address space size.
// - Two consecutive read-only words hold the ASCII block name.
// - State code sits in low four bits of status word, resets to 9.
// - Start in code 9, then go to code 0 once the synchronised id pin reads low.
// - A-device: code 1 waiting VBus valid, code 2 waiting connection.
// - A-device: code 3 host, 4 suspended host, 5 peripheral.
// - A-device: code 6 waiting VBus fall, 7 over-current recovery.
// - A-device: code 8 during 100 us line discharge.
// - B-device: code 10 peripheral, 11 suspended waiting 3 ms before negotiation.
// - B-device: code 12 discharging 100 us, 13 waiting for A connect.
// - B-device: code 14 host, 15 session request in progress.
`timescale 1ns/1ps
module uocr_top
  import uocr_pkg::*;
#(
  parameter int DISCHARGE_CNT = DISCHARGE_CYCLES,
  parameter int HNP_WAIT_CNT  = HNP_WAIT_CYCLES
)
(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // Register port
  input  wire logic              reg_sel,
  input  wire logic              reg_wr,
  input  wire logic [11:0]       reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  // Pins from the line side
  input  wire logic              id_pin,
  input  wire logic              vbus_valid_pin,
  input  wire logic              session_valid_pin,
  input  wire logic              overcurrent_pin,
  input  wire logic              far_connect_pin,
  input  wire logic              line_suspend_pin,
  input  wire logic              line_resume_pin,
  // Requests from local control logic
  input  wire logic              bus_request,
  input  wire logic              bus_drop,
  input  wire logic              srp_request,
  input  wire logic              hnp_request,
  input  wire logic              hnp_enabled,
  input  wire logic              host_done,
  // Role status
  output uocr_pkg::uocr_state_t  dual_role_state_code,
  output logic                   host_role,
  output logic                   vbus_drive,
  output logic                   peripheral_role,
  output logic                   discharge_active
);
  import uocr_pkg::*;

  typedef struct packed {
    uocr_state_t state;
    logic [1:0]  settle;
    logic [31:0] rdata;
    logic        rvalid;
    logic        host_role;
    logic        vbus_drive;
    logic        peripheral_role;
    logic        discharge_active;
  } uocr_top_t;

  localparam uocr_top_t RESET_S = '{
    state:            uocr_state_t'(ROLE_STATE_RESET[3:0]),
    settle:           2'h0,
    rdata:            32'h00000000,
    rvalid:           1'b0,
    host_role:        1'b0,
    vbus_drive:       1'b0,
    peripheral_role:  1'b0,
    discharge_active: 1'b0
  };

  uocr_top_t s;
  uocr_top_t next_s;

  logic [PIN_W-1:0]   pins;
  logic [PIN_W-1:0]   pins_q;
  logic               timer_start;
  logic [TIMER_W-1:0] timer_load;
  logic               timer_done;
  logic [31:0]        capability_word;
  logic [31:0]        role_state_status;

  assign pins[PIN_ID]           = id_pin;
  assign pins[PIN_VBUS_VALID]   = vbus_valid_pin;
  assign pins[PIN_SESS_VALID]   = session_valid_pin;
  assign pins[PIN_OVERCURRENT]  = overcurrent_pin;
  assign pins[PIN_FAR_CONNECT]  = far_connect_pin;
  assign pins[PIN_LINE_SUSPEND] = line_suspend_pin;
  assign pins[PIN_LINE_RESUME]  = line_resume_pin;

  uocr_sync u_sync (
    .clk       (clk),
    .reset_n   (reset_n),
    .pin_async (pins),
    .pin_sync  (pins_q)
  );

  uocr_timer u_timer (
    .clk     (clk),
    .reset_n (reset_n),
    .start   (timer_start),
    .load    (timer_load),
    .done    (timer_done)
  );

  logic id_q;
  logic vbus_ok;
  logic sess_ok;
  logic ovc;
  logic far_conn;
  logic suspend_seen;
  logic resume_seen;

  assign id_q         = pins_q[PIN_ID];
  assign vbus_ok      = pins_q[PIN_VBUS_VALID];
  assign sess_ok      = pins_q[PIN_SESS_VALID];
  assign ovc          = pins_q[PIN_OVERCURRENT];
  assign far_conn     = pins_q[PIN_FAR_CONNECT];
  assign suspend_seen = pins_q[PIN_LINE_SUSPEND];
  assign resume_seen  = pins_q[PIN_LINE_RESUME];

  genvar ep;
  generate
    for (ep = 0; ep < HB_ISO_EPS; ep++)
    begin : g_hb_iso
      assign capability_word[HB_ISO_LSB + ep] = HB_ISO_SUPPORTED_N[ep];
    end
  endgenerate

  assign capability_word[31:HB_ISO_LSB + HB_ISO_EPS] = '0;
  assign capability_word[UTMI_FLAG_BIT] = UTMI_PATH_WIDTH_FLAG;
  assign capability_word[BYTE_LANE_BIT] = NATIVE_BYTE_LANE_FLAG;
  assign capability_word[MEM_SIZE_LSB +: 3] = PACKET_MEMORY_SIZE_CODE;
  assign capability_word[FIFO_DEPTH_LSB +: 4] = DMA_FIFO_DEPTH_CODE;
  assign capability_word[DMA_LEN_BIT] = DMA_LENGTH_WIDTH_FLAG;
  assign capability_word[DMA_CHAN_LSB +: 3] = DMA_CHANNEL_COUNT;
  assign capability_word[ENDPOINT_CNT_LSB +: 4] = ENDPOINT_COUNT;

  assign role_state_status = {28'h0000000, s.state};

  // Timer loads on entry to a timed state; counts from other states are ignored
  always_comb
  begin
    timer_start = 1'b0;
    timer_load = TIMER_W'(DISCHARGE_CNT);
    if (next_s.state != s.state)
    begin
      case (next_s.state)
        A_WAIT_DISCHARGE,
        B_WAIT_DISCHARGE:
        begin
          timer_start = 1'b1;
          timer_load = TIMER_W'(DISCHARGE_CNT);
        end
        B_WAIT_BEGIN_HNP:
        begin
          timer_start = 1'b1;
          timer_load = TIMER_W'(HNP_WAIT_CNT);
        end
        default:
        begin
          timer_start = 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    next_s = s;
    next_s.rvalid = 1'b0;

    // Reads answer one cycle later
    // Writes are accepted and dropped
    if (reg_sel && !reg_wr)
    begin
      next_s.rvalid = 1'b1;
      case (reg_addr)
        CAPABILITY_WORD_OFS:     next_s.rdata = capability_word;
        ADDRESS_SPACE_SIZE_OFS:  next_s.rdata = ADDRESS_SPACE_SIZE;
        BLOCK_NAME_PART_ONE_OFS: next_s.rdata = BLOCK_NAME_PART_ONE;
        BLOCK_NAME_PART_TWO_OFS: next_s.rdata = BLOCK_NAME_PART_TWO;
        ROLE_STATE_STATUS_OFS:   next_s.rdata = role_state_status;
        default:                 next_s.rdata = 32'h00000000;
      endcase
    end
    else if (reg_sel && reg_wr)
    begin
      next_s.rvalid = 1'b1;
      next_s.rdata = 32'h00000000;
    end

    // Id synchroniser needs a few edges before it is trusted
    if (s.settle != 2'(SETTLE_CYCLES))
      next_s.settle = s.settle + 2'h1;

    if (s.settle == 2'(SETTLE_CYCLES))
    begin
      case (s.state)
        A_IDLE:
        begin
          if (id_q)
            next_s.state = B_IDLE;
          else if (bus_request && !bus_drop)
            next_s.state = A_WAIT_VRISE;
        end
        A_WAIT_VRISE:
        begin
          if (id_q || ovc)
            next_s.state = ovc ? A_VBUS_ERR : A_WAIT_VFALL;
          else if (bus_drop)
            next_s.state = A_WAIT_VFALL;
          else if (vbus_ok)
            next_s.state = A_WAIT_BCON;
        end
        A_WAIT_BCON:
        begin
          if (ovc)
            next_s.state = A_VBUS_ERR;
          else if (id_q || bus_drop)
            next_s.state = A_WAIT_VFALL;
          else if (far_conn)
            next_s.state = A_HOST;
        end
        A_HOST:
        begin
          if (ovc)
            next_s.state = A_VBUS_ERR;
          else if (id_q || bus_drop)
            next_s.state = A_WAIT_VFALL;
          else if (!far_conn)
            next_s.state = A_WAIT_BCON;
          else if (!bus_request)
            next_s.state = A_SUSPEND;
        end
        A_SUSPEND:
        begin
          if (ovc)
            next_s.state = A_VBUS_ERR;
          else if (id_q || bus_drop)
            next_s.state = A_WAIT_VFALL;
          else if (!far_conn && hnp_enabled)
            next_s.state = A_PERIPHERAL;
          else if (bus_request || resume_seen)
            next_s.state = A_HOST;
        end
        A_PERIPHERAL:
        begin
          if (ovc)
            next_s.state = A_VBUS_ERR;
          else if (id_q || bus_drop)
            next_s.state = A_WAIT_VFALL;
          else if (suspend_seen)
            next_s.state = A_WAIT_DISCHARGE;
        end
        A_WAIT_VFALL:
        begin
          if (!sess_ok)
            next_s.state = A_IDLE;
        end
        A_VBUS_ERR:
        begin
          if (!ovc)
            next_s.state = A_WAIT_VFALL;
        end
        A_WAIT_DISCHARGE:
        begin
          if (ovc)
            next_s.state = A_VBUS_ERR;
          else if (timer_done)
            next_s.state = A_WAIT_BCON;
        end
        // B idle, may request a session
        B_IDLE:
        begin
          if (!id_q)
            next_s.state = A_IDLE;
          else if (sess_ok)
            next_s.state = B_PERIPHERAL;
          else if (srp_request)
            next_s.state = B_SRP_INIT;
        end
        B_PERIPHERAL:
        begin
          if (!id_q || !sess_ok)
            next_s.state = B_IDLE;
          else if (suspend_seen && hnp_request && hnp_enabled)
            next_s.state = B_WAIT_BEGIN_HNP;
        end
        B_WAIT_BEGIN_HNP:
        begin
          if (!id_q || !sess_ok)
            next_s.state = B_IDLE;
          else if (resume_seen || !hnp_request)
            next_s.state = B_PERIPHERAL;
          else if (timer_done)
            next_s.state = B_WAIT_DISCHARGE;
        end
        // Discharge, then wait for A connect
        B_WAIT_DISCHARGE:
        begin
          if (!id_q || !sess_ok)
            next_s.state = B_IDLE;
          else if (timer_done)
            next_s.state = B_WAIT_ACON;
        end
        B_WAIT_ACON:
        begin
          if (!id_q || !sess_ok)
            next_s.state = B_IDLE;
          else if (far_conn)
            next_s.state = B_HOST;
          else if (resume_seen)
            next_s.state = B_PERIPHERAL;
        end
        B_HOST:
        begin
          if (!id_q || !sess_ok)
            next_s.state = B_IDLE;
          else if (host_done || !far_conn)
            next_s.state = B_PERIPHERAL;
        end
        B_SRP_INIT:
        begin
          if (!id_q)
            next_s.state = A_IDLE;
          else if (sess_ok)
            next_s.state = B_PERIPHERAL;
          else if (!srp_request)
            next_s.state = B_IDLE;
        end
        default:
        begin
          next_s.state = B_IDLE;
        end
      endcase
    end

    // Role outputs decode the next state and register with it, in step with the state
    next_s.host_role = (next_s.state == A_HOST) || (next_s.state == A_SUSPEND)
                       || (next_s.state == B_HOST);
    next_s.vbus_drive = (next_s.state == A_WAIT_VRISE) || (next_s.state == A_WAIT_BCON)
                        || (next_s.state == A_HOST) || (next_s.state == A_SUSPEND)
                        || (next_s.state == A_PERIPHERAL)
                        || (next_s.state == A_WAIT_DISCHARGE);
    next_s.peripheral_role = (next_s.state == A_PERIPHERAL)
                             || (next_s.state == B_PERIPHERAL)
                             || (next_s.state == B_WAIT_BEGIN_HNP);
    next_s.discharge_active = (next_s.state == A_WAIT_DISCHARGE)
                              || (next_s.state == B_WAIT_DISCHARGE);
  end

  always_ff @(posedge clk)
  begin
    if (!reset_n)
      s <= RESET_S;
    else
      s <= next_s;
  end

  assign reg_rdata            = s.rdata;
  assign reg_rvalid           = s.rvalid;
  assign dual_role_state_code = s.state;
  assign host_role            = s.host_role;
  assign vbus_drive           = s.vbus_drive;
  assign peripheral_role      = s.peripheral_role;
  assign discharge_active     = s.discharge_active;
endmodule // uocr_top

// File: tb/uocr_far.sv
`timescale 1ns/1ps
module uocr_far
  import uocr_pkg::*;
(
  // Clock
  input  wire logic                       clk,
  // Line-side levels, synchroniser bit order
  output logic      [uocr_pkg::PIN_W-1:0] pins
);
  // Levels move off the sampling edge only
  task automatic drive(input logic [PIN_W-1:0] v);
    @(negedge clk);
    pins = v;
  endtask

  // Start as a B-side plug, nothing on the line
  initial pins = 7'h01;
endmodule // uocr_far

// File: tb/uocr_chk.sv
`timescale 1ns/1ps
module uocr_chk
  import uocr_pkg::*;
#(
  parameter int DISCHARGE_CNT = 8,
  parameter int HNP_WAIT_CNT  = 16
)
(
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset_n,
  // Register port
  input wire logic                  reg_sel,
  input wire logic                  reg_wr,
  input wire logic [11:0]           reg_addr,
  input wire logic [31:0]           reg_rdata,
  input wire logic                  reg_rvalid,
  // Local requests
  input wire logic                  bus_request,
  input wire logic                  bus_drop,
  // Role status
  input wire uocr_pkg::uocr_state_t dual_role_state_code,
  input wire logic                  host_role,
  input wire logic                  vbus_drive,
  input wire logic                  peripheral_role,
  input wire logic                  discharge_active
);
  localparam logic [31:0] CAP = {8'h00, HB_ISO_SUPPORTED_N, UTMI_PATH_WIDTH_FLAG,
    NATIVE_BYTE_LANE_FLAG, PACKET_MEMORY_SIZE_CODE, DMA_FIFO_DEPTH_CODE,
    DMA_LENGTH_WIDTH_FLAG, DMA_CHANNEL_COUNT, ENDPOINT_COUNT};
  uocr_state_t st;
  uocr_state_t prev;
  logic [19:0] dwell;
  logic        rd;
  assign st = dual_role_state_code;
  assign rd = reg_sel && !reg_wr;

  // Run length of the current state; timer exits are judged on it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
    begin
      prev  <= B_IDLE;
      dwell <= 20'h00000;
    end
    else
    begin
      prev  <= st;
      dwell <= (st != prev) ? 20'h00001 : dwell + 20'h00001;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  chk_rvalid_after_sel: assert property (reg_sel |=> reg_rvalid)
    else $error("no answer one cycle after an access");
  chk_rvalid_has_cause: assert property (reg_rvalid |-> $past(reg_sel))
    else $error("answer without an access");
  chk_cap_word_read: assert property (
    rd && reg_addr == CAPABILITY_WORD_OFS |=> reg_rdata == CAP)
    else $error("capability word wrong");
  chk_size_word_read: assert property (
    rd && reg_addr == ADDRESS_SPACE_SIZE_OFS |=> reg_rdata == ADDRESS_SPACE_SIZE)
    else $error("size word wrong");
  chk_name_one_read: assert property (
    rd && reg_addr == BLOCK_NAME_PART_ONE_OFS |=> reg_rdata == BLOCK_NAME_PART_ONE)
    else $error("first name word wrong");
  chk_state_word_read: assert property (
    rd && reg_addr == ROLE_STATE_STATUS_OFS |=> reg_rdata == {28'h0000000, $past(st)})
    else $error("state word does not match state");
  chk_write_reads_zero: assert property (
    reg_sel && reg_wr |=> reg_rdata == 32'h00000000)
    else $error("write returned data");
  chk_role_flags_match: assert property (
    host_role == (st inside {A_HOST, A_SUSPEND, B_HOST})
    && peripheral_role == (st inside {A_PERIPHERAL, B_PERIPHERAL, B_WAIT_BEGIN_HNP})
    && discharge_active == (st inside {A_WAIT_DISCHARGE, B_WAIT_DISCHARGE}))
    else $error("role flags disagree with state");
  chk_vbus_drive_match: assert property (
    vbus_drive == (st inside {A_WAIT_VRISE, A_WAIT_BCON, A_HOST, A_SUSPEND, A_PERIPHERAL,
    A_WAIT_DISCHARGE}))
    else $error("supply drive disagrees with state");
  chk_a_start_request: assert property (
    st == A_IDLE && bus_request && !bus_drop |=> st == A_WAIT_VRISE)
    else $error("bus request did not leave idle");
  chk_a_discharge_time: assert property (
    $past(st) == A_WAIT_DISCHARGE && st == A_WAIT_BCON |-> dwell == DISCHARGE_CNT + 1)
    else $error("discharge wait has wrong length");
  chk_b_hnp_wait_time: assert property (
    $past(st) == B_WAIT_BEGIN_HNP && st == B_WAIT_DISCHARGE |-> dwell == HNP_WAIT_CNT + 1)
    else $error("negotiation wait has wrong length");
  chk_b_discharge_time: assert property (
    $past(st) == B_WAIT_DISCHARGE && st == B_WAIT_ACON |-> dwell == DISCHARGE_CNT + 1)
    else $error("discharge before host has wrong length");

  cov_a_discharge: cover property (st == A_WAIT_DISCHARGE ##1 st == A_WAIT_BCON);
  cov_b_host: cover property (st == B_HOST);
  cov_srp: cover property (st == B_SRP_INIT);
endmodule // uocr_chk

bind uocr_top uocr_chk #(
  .DISCHARGE_CNT(DISCHARGE_CNT),
  .HNP_WAIT_CNT (HNP_WAIT_CNT)
) uocr_chk_inst (
  .clk(clk), .reset_n(reset_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
  .reg_addr(reg_addr), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
  .bus_request(bus_request), .bus_drop(bus_drop),
  .dual_role_state_code(dual_role_state_code), .host_role(host_role),
  .vbus_drive(vbus_drive), .peripheral_role(peripheral_role),
  .discharge_active(discharge_active)
);

// File: tb/tb_usb_otg_capability_and_role_state.sv
`timescale 1ns/1ps
module tb_usb_otg_capability_and_role_state;
  import uocr_pkg::*;
  localparam int DIS = 8;
  localparam int HNP = 16;
  localparam logic [31:0] CAP = {8'h00, HB_ISO_SUPPORTED_N, UTMI_PATH_WIDTH_FLAG,
    NATIVE_BYTE_LANE_FLAG, PACKET_MEMORY_SIZE_CODE, DMA_FIFO_DEPTH_CODE,
    DMA_LENGTH_WIDTH_FLAG, DMA_CHANNEL_COUNT, ENDPOINT_COUNT};
  logic             clk;
  logic             reset_n;
  logic             reg_sel;
  logic             reg_wr;
  logic [11:0]      reg_addr;
  logic [31:0]      reg_wdata;
  logic [31:0]      reg_rdata;
  logic             reg_rvalid;
  logic [PIN_W-1:0] pins;
  logic [5:0]       loc;
  logic [3:0]       roles;
  uocr_state_t      state;
  logic [31:0]      rd;
  int               errors;
  int               checks;

  uocr_far uocr_far_inst (.clk(clk), .pins(pins));

  // Local request bits: request, drop, srp, hnp, hnp enable, host done
  uocr_top #(.DISCHARGE_CNT(DIS), .HNP_WAIT_CNT(HNP)) uocr_top_inst (
    .clk(clk), .reset_n(reset_n), .reg_sel(reg_sel), .reg_wr(reg_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .id_pin(pins[PIN_ID]), .vbus_valid_pin(pins[PIN_VBUS_VALID]),
    .session_valid_pin(pins[PIN_SESS_VALID]), .overcurrent_pin(pins[PIN_OVERCURRENT]),
    .far_connect_pin(pins[PIN_FAR_CONNECT]), .line_suspend_pin(pins[PIN_LINE_SUSPEND]),
    .line_resume_pin(pins[PIN_LINE_RESUME]), .bus_request(loc[0]), .bus_drop(loc[1]),
    .srp_request(loc[2]), .hnp_request(loc[3]), .hnp_enabled(loc[4]), .host_done(loc[5]),
    .dual_role_state_code(state), .host_role(roles[0]), .vbus_drive(roles[1]),
    .peripheral_role(roles[2]), .discharge_active(roles[3])
  );

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Answer stands only in the cycle after the taking edge
  task automatic access(input logic wr, input logic [11:0] addr, output logic [31:0] data);
    @(negedge clk);
    reg_sel   = 1'b1;
    reg_wr    = wr;
    reg_addr  = addr;
    reg_wdata = 32'hFFFFFFFF;
    @(negedge clk);
    cmp("rvalid", 32'h00000001, {31'h00000000, reg_rvalid});
    data = reg_rdata;
    reg_sel = 1'b0;
  endtask

  task automatic wait_state(input uocr_state_t exp);
    int n;
    n = 0;
    while (state !== exp && n < 60)
    begin
      @(negedge clk);
      n++;
    end
    cmp("state", {28'h0000000, exp}, {28'h0000000, state});
    if (state !== exp)
      end_sim();
  endtask

  task automatic step(input logic [6:0] p, input logic [5:0] l, input uocr_state_t exp);
    uocr_far_inst.drive(p);
    loc = l;
    wait_state(exp);
  endtask

  task automatic test_regs();
    logic [11:0] addrs [6];
    logic [31:0] exps [6];
    addrs = '{CAPABILITY_WORD_OFS, ADDRESS_SPACE_SIZE_OFS, BLOCK_NAME_PART_ONE_OFS,
              BLOCK_NAME_PART_TWO_OFS, ROLE_STATE_STATUS_OFS, 12'h830};
    exps  = '{CAP, ADDRESS_SPACE_SIZE, BLOCK_NAME_PART_ONE, BLOCK_NAME_PART_TWO,
              ROLE_STATE_RESET, 32'h00000000};
    for (int i = 0; i < 6; i++)
    begin
      access(1'b0, addrs[i], rd);
      cmp("read word", exps[i], rd);
      access(1'b1, addrs[i], rd);
      cmp("write answer", 32'h00000000, rd);
      access(1'b0, addrs[i], rd);
      cmp("read after write", exps[i], rd);
    end
    $display("test regs done");
  endtask

  task automatic test_a_path();
    step(7'h04, 6'h00, A_IDLE);
    step(7'h04, 6'h01, A_WAIT_VRISE);
    step(7'h06, 6'h01, A_WAIT_BCON);
    step(7'h16, 6'h01, A_HOST);
    cmp("roles", 32'h00000003, {28'h0000000, roles});
    step(7'h16, 6'h10, A_SUSPEND);
    step(7'h06, 6'h10, A_PERIPHERAL);
    cmp("roles", 32'h00000006, {28'h0000000, roles});
    step(7'h26, 6'h10, A_WAIT_DISCHARGE);
    cmp("roles", 32'h0000000A, {28'h0000000, roles});
    wait_state(A_WAIT_BCON);
    access(1'b0, ROLE_STATE_STATUS_OFS, rd);
    cmp("state word", 32'h00000002, rd);
    step(7'h0E, 6'h10, A_VBUS_ERR);
    step(7'h06, 6'h10, A_WAIT_VFALL);
    step(7'h02, 6'h00, A_IDLE);
    $display("test a path done");
  endtask

  task automatic test_b_path();
    uocr_far_inst.drive(7'h01);
    @(negedge clk);
    reset_n = 1'b0;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    access(1'b0, ROLE_STATE_STATUS_OFS, rd);
    cmp("state after reset", ROLE_STATE_RESET, rd);
    step(7'h05, 6'h00, B_PERIPHERAL);
    step(7'h25, 6'h18, B_WAIT_BEGIN_HNP);
    wait_state(B_WAIT_DISCHARGE);
    wait_state(B_WAIT_ACON);
    step(7'h15, 6'h18, B_HOST);
    cmp("roles", 32'h00000001, {28'h0000000, roles});
    step(7'h15, 6'h20, B_PERIPHERAL);
    step(7'h11, 6'h00, B_IDLE);
    step(7'h11, 6'h04, B_SRP_INIT);
    step(7'h11, 6'h00, B_IDLE);
    $display("test b path done");
  endtask

  initial
  begin
    errors    = 0;
    checks    = 0;
    reset_n   = 1'b0;
    reg_sel   = 1'b0;
    reg_wr    = 1'b0;
    reg_addr  = 12'h000;
    reg_wdata = 32'h00000000;
    loc       = 6'h00;
    repeat (2) @(negedge clk);
    reset_n = 1'b1;
    test_regs();
    test_a_path();
    test_b_path();
    end_sim();
  end
endmodule // tb_usb_otg_capability_and_role_state
